/* File: hw/lcdte_engine.sv */
/*
 * Text/graphic display engine: display memory, glyph writer, cursor,
 * window, icon row, scrolling, blink and the scan-out byte path.
 * Assumes an Avalon-MM master, a font ROM answering one cycle after
 * font_rd, and frame_tick / scan address from logic on clk_sys.
 */
`timescale 1ns/1ns
`default_nettype none
module lcdte_engine (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic font_rd,
   output logic [lcdte_pkg::FONT_AW-1:0] font_addr,
   input wire logic [7:0] font_data,
   input wire logic frame_tick,
   input wire logic [5:0] scan_row,
   input wire logic [3:0] scan_col,
   output logic [7:0] scan_data
);
   import lcdte_pkg::*;

   logic [7:0] mem [0:MEM_BYTES-1];
   logic [31:0] mode_q, mode_d, blink_q, blink_d, cur_q, cur_d;
   logic [31:0] sys_q, sys_d, hscr_q, hscr_d, vscr_q, vscr_d;
   logic [31:0] speed_q, speed_d, rdata_q, rdata_d;
   logic [3:0] col_q, col_d, gr_q, gr_d;
   logic [6:0] row_q, row_d, hoff_q, hoff_d, blk_q, blk_d, hunit;
   logic [7:0] hi_q, hi_d, spd_q, spd_d, wbyte, sty_out, scan_q, scan_d;
   logic [15:0] code_q, code_d;
   logic [9:0] clr_q, clr_d, mem_wa;
   logic [4:0] voff_q, voff_d, vunit, win_rows_m1;
   logic [FONT_AW-1:0] font_addr_q, font_addr_d;
   lcdte_state_e st_q, st_d;
   lcdte_style_e sty_q, sty_d;
   logic pend_q, pend_d, gb_q, gb_d, gfull_q, gfull_d, gh8_q, gh8_d;
   logic phase_q, phase_d, rdv_q, font_rd_q, font_rd_d, mem_we;
   logic busy, wr_go, data_wr, gfx, gfx_wr, hi_take, code_go, clr_go;
   logic icon, glyph_last, st_ok, adv, step, in_win;
   logic [3:0] win_cols_m1;
   logic [5:0] mrow, srow;
   logic [4:0] scol;
   logic [7:0] mem_wd;

   assign gfx = mode_q[MODE_FM +: 2] == FM_GRAPHICS;
   assign win_cols_m1 = sys_q[SYS_COLS +: 4];
   assign win_rows_m1 = sys_q[SYS_ROWS +: 5];
   assign icon = row_q == ICON_ROW_CODE;
   assign mrow = icon ? ICON_MEM_ROW : {1'b0, row_q[4:0]};
   assign busy = st_q != ST_IDLE;
   assign wr_go = avs_write & ~busy;
   assign wbyte = avs_writedata[7:0];
   assign data_wr = wr_go & avs_byteenable[0]
      & (avs_address[5:2] == IDX_DATA);
   assign gfx_wr = data_wr & gfx;
   assign hi_take = data_wr & ~gfx & ~pend_q & wbyte[7];
   assign code_go = data_wr & ~gfx & (pend_q | ~wbyte[7]);
   assign clr_go = wr_go & avs_byteenable[0]
      & (avs_address[5:2] == IDX_PWR) & wbyte[PWR_CLR];
   assign glyph_last = (gb_q == gfull_q)
      && (gr_q == (gh8_q ? 4'h7 : 4'hf));
   assign srow = mrow + {2'h0, gr_q};
   assign scol = {1'b0, col_q} + {4'h0, gb_q};
   assign st_ok = (srow < MEM_ROWS) && !scol[4];
   assign step = frame_tick && (spd_q == speed_q[7:0]);
   assign hunit = 7'h01 << hscr_q[SCR_UNIT +: 3];
   assign vunit = 5'h01 << vscr_q[SCR_UNIT +: 3];
   assign avs_waitrequest = avs_read ? ~rdv_q : (avs_write & busy);
   assign avs_readdata = rdata_q;
   assign font_rd = font_rd_q;
   assign font_addr = font_addr_q;
   assign scan_data = scan_q;

   lcdte_style u_glyph_style (
      .raw(font_data),
      .style(sty_q),
      .styled(sty_out)
   );

   always_comb begin
      logic [4:0] aw, ncol;
      logic [6:0] ah, nrow;
      aw = 5'h01;
      ah = 7'h01;
      ncol = 5'h00;
      nrow = 7'h00;
      adv = 1'b0;
      mode_d = mode_q;
      blink_d = blink_q;
      cur_d = cur_q;
      sys_d = sys_q;
      hscr_d = hscr_q;
      vscr_d = vscr_q;
      speed_d = speed_q;
      col_d = col_q;
      row_d = row_q;
      hi_d = hi_q;
      pend_d = pend_q;
      st_d = st_q;
      code_d = code_q;
      gr_d = gr_q;
      gb_d = gb_q;
      gfull_d = gfull_q;
      gh8_d = gh8_q;
      sty_d = sty_q;
      clr_d = clr_q;
      font_rd_d = 1'b0;
      font_addr_d = font_addr_q;
      hoff_d = hoff_q;
      voff_d = voff_q;
      spd_d = spd_q;
      blk_d = blk_q;
      phase_d = phase_q;
      if (wr_go) begin
         case (avs_address[5:2])
            IDX_MODE: mode_d = lcdte_merge(mode_q, avs_writedata,
               avs_byteenable) & MASK_MODE;
            IDX_BLINK: blink_d = lcdte_merge(blink_q, avs_writedata,
               avs_byteenable) & MASK_BLINK;
            IDX_CUR: cur_d = lcdte_merge(cur_q, avs_writedata,
               avs_byteenable) & MASK_CUR;
            IDX_SYS: sys_d = lcdte_merge(sys_q, avs_writedata,
               avs_byteenable) & MASK_SYS;
            IDX_HSCR: hscr_d = lcdte_merge(hscr_q, avs_writedata,
               avs_byteenable) & MASK_HSCR;
            IDX_VSCR: vscr_d = lcdte_merge(vscr_q, avs_writedata,
               avs_byteenable) & MASK_VSCR;
            IDX_SPEED: speed_d = lcdte_merge(speed_q, avs_writedata,
               avs_byteenable) & MASK_SPEED;
            IDX_COL: if (avs_byteenable[0]) col_d = wbyte[3:0];
            IDX_ROW: if (avs_byteenable[0]) row_d = wbyte[6:0];
            default: ;
         endcase
      end
      unique case (st_q)
         ST_IDLE: begin
            if (clr_go) begin
               st_d = ST_CLEAR;
               clr_d = 10'h000;
            end else if (hi_take) begin
               hi_d = wbyte;
               pend_d = 1'b1;
            end else if (code_go) begin
               code_d = pend_q ? {hi_q, wbyte} : {8'h00, wbyte};
               gfull_d = pend_q | mode_q[MODE_FULL];
               gh8_d = ~(pend_q | mode_q[MODE_FULL]) & mode_q[MODE_H8];
               sty_d = lcdte_style_e'(mode_q[MODE_STY +: 2]);
               gr_d = 4'h0;
               gb_d = 1'b0;
               pend_d = 1'b0;
               st_d = ST_FETCH;
            end else if (gfx_wr) begin
               adv = 1'b1;
            end
         end
         ST_FETCH: begin
            font_rd_d = 1'b1;
            font_addr_d = {mode_q[MODE_FM +: 2], code_q, gr_q, gb_q};
            st_d = ST_WAIT;
         end
         ST_WAIT: st_d = ST_STORE;
         ST_STORE: begin
            if (glyph_last) begin
               st_d = ST_IDLE;
               adv = 1'b1;
               aw = gfull_q ? 5'h02 : 5'h01;
               ah = {2'h0, gh8_q ? GLYPH_H8 : GLYPH_H16};
            end else begin
               if (gfull_q && !gb_q) begin
                  gb_d = 1'b1;
               end else begin
                  gb_d = 1'b0;
                  gr_d = gr_q + 4'h1;
               end
               st_d = ST_FETCH;
            end
         end
         ST_CLEAR: begin
            clr_d = clr_q + 10'h001;
            if (clr_q == CLR_LAST) st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
      if (adv) begin
         ncol = {1'b0, col_q} + aw;
         if (ncol > {1'b0, win_cols_m1}) begin
            col_d = 4'h0;
            if (!icon) begin
               nrow = {2'h0, row_q[4:0]} + ah;
               row_d = (nrow > {2'h0, win_rows_m1}) ? 7'h00 : nrow;
            end
         end else begin
            col_d = ncol[3:0];
         end
      end
      if (frame_tick) begin
         if (blk_q == {blink_q[BLK_PER +: 4], 3'h7}) begin
            blk_d = 7'h00;
            phase_d = ~phase_q;
         end else begin
            blk_d = blk_q + 7'h01;
         end
         spd_d = step ? 8'h00 : spd_q + 8'h01;
      end
      if (step && hscr_q[SCR_EN]) begin
         hoff_d = hscr_q[SCR_DIR] ? hoff_q - hunit : hoff_q + hunit;
      end
      if (step && vscr_q[SCR_EN]) begin
         voff_d = vscr_q[SCR_DIR] ? voff_q - vunit : voff_q + vunit;
      end
      rdata_d = rdata_q;
      if (avs_read && !rdv_q) begin
         case (avs_address[5:2])
            IDX_MODE: rdata_d = mode_q;
            IDX_PWR: rdata_d = {31'h0, st_q == ST_CLEAR};
            IDX_BLINK: rdata_d = blink_q;
            IDX_COL: rdata_d = {28'h0, col_q};
            IDX_ROW: rdata_d = {25'h0, row_q};
            IDX_CUR: rdata_d = cur_q;
            IDX_SYS: rdata_d = sys_q;
            IDX_DATA: rdata_d = {30'h0, pend_q, busy};
            IDX_HSCR: rdata_d = hscr_q;
            IDX_VSCR: rdata_d = vscr_q;
            IDX_SPEED: rdata_d = speed_q;
            default: rdata_d = 32'h0;
         endcase
      end
   end

   always_comb begin
      mem_we = 1'b1;
      mem_wa = clr_q;
      mem_wd = 8'h00;
      if (st_q == ST_STORE) begin
         mem_we = st_ok;
         mem_wa = {srow, scol[3:0]};
         mem_wd = sty_out;
      end else if (st_q != ST_CLEAR) begin
         mem_we = gfx_wr;
         mem_wa = {mrow, col_q};
         mem_wd = wbyte;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (mem_we) mem[mem_wa] <= mem_wd;
   end

   // scan-out byte: scroll, blink/invert area, cursor overlay
   logic [7:0] gfx_in, gfx_out;
   logic inv_on;
   lcdte_style u_scan_style (
      .raw(gfx_in),
      .style(inv_on ? STY_INVERSE : STY_NORMAL),
      .styled(gfx_out)
   );

   always_comb begin
      logic [5:0] vrow;
      logic [6:0] x, ctop, cbot, ceff, ccell;
      logic [15:0] pair;
      logic hreg, vcol, area, cur_vis;
      hreg = (scan_row[4:0] >= hscr_q[HS_TOP +: 5])
         && (scan_row[4:0] <= hscr_q[HS_BOT +: 5]) && !scan_row[5];
      vcol = (scan_col >= vscr_q[VS_LEFT +: 4])
         && (scan_col <= vscr_q[VS_RIGHT +: 4]);
      area = hreg && vcol;
      vrow = scan_row;
      if (vscr_q[SCR_EN] && vcol && !scan_row[5]) begin
         vrow = {1'b0, scan_row[4:0] + voff_q};
      end
      x = {scan_col, 3'h0};
      if (hscr_q[SCR_EN] && hreg) x = x + hoff_q;
      pair = {mem[{vrow, x[6:3]}], mem[{vrow, x[6:3] + 4'h1}]} << x[2:0];
      gfx_in = pair[15:8];
      inv_on = gfx && area && blink_q[BLK_INV];
      scan_d = gfx_out;
      if (gfx && area && blink_q[BLK_EN] && phase_q) scan_d = 8'h00;
      ccell = {2'h0, (mode_q[MODE_FULL] || !mode_q[MODE_H8])
         ? GLYPH_H16 : GLYPH_H8};
      ceff = {3'h0, cur_q[CUR_H +: 4]} + 7'h01;
      if (ceff > ccell) ceff = ccell;
      ctop = {1'b0, mrow} + ccell - ceff;
      cbot = {1'b0, mrow} + ccell - 7'h01;
      cur_vis = cur_q[CUR_ON] && !(cur_q[CUR_BLK] && phase_q)
         && ({1'b0, scan_row} >= ctop) && ({1'b0, scan_row} <= cbot)
         && ((scan_col == col_q)
         || (mode_q[MODE_FULL] && scan_col == col_q + 4'h1));
      if (cur_vis) scan_d = ~scan_d;
      in_win = (scan_row == ICON_MEM_ROW) || (!scan_row[5]
         && scan_row[4:0] <= win_rows_m1 && scan_col <= win_cols_m1);
      if (!in_win) scan_d = 8'h00;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_q <= RST_MODE;
         blink_q <= RST_BLINK;
         cur_q <= RST_CUR;
         sys_q <= RST_SYS;
         hscr_q <= RST_HSCR;
         vscr_q <= RST_VSCR;
         speed_q <= RST_SPEED;
         col_q <= 4'h0;
         row_q <= 7'h00;
         hi_q <= 8'h00;
         pend_q <= 1'b0;
         st_q <= ST_IDLE;
         code_q <= 16'h0000;
         gr_q <= 4'h0;
         gb_q <= 1'b0;
         gfull_q <= 1'b0;
         gh8_q <= 1'b0;
         sty_q <= STY_NORMAL;
         clr_q <= 10'h000;
         font_rd_q <= 1'b0;
         font_addr_q <= '0;
         hoff_q <= 7'h00;
         voff_q <= 5'h00;
         spd_q <= 8'h00;
         blk_q <= 7'h00;
         phase_q <= 1'b0;
         rdv_q <= 1'b0;
         rdata_q <= 32'h0;
         scan_q <= 8'h00;
      end else begin
         mode_q <= mode_d;
         blink_q <= blink_d;
         cur_q <= cur_d;
         sys_q <= sys_d;
         hscr_q <= hscr_d;
         vscr_q <= vscr_d;
         speed_q <= speed_d;
         col_q <= col_d;
         row_q <= row_d;
         hi_q <= hi_d;
         pend_q <= pend_d;
         st_q <= st_d;
         code_q <= code_d;
         gr_q <= gr_d;
         gb_q <= gb_d;
         gfull_q <= gfull_d;
         gh8_q <= gh8_d;
         sty_q <= sty_d;
         clr_q <= clr_d;
         font_rd_q <= font_rd_d;
         font_addr_q <= font_addr_d;
         hoff_q <= hoff_d;
         voff_q <= voff_d;
         spd_q <= spd_d;
         blk_q <= blk_d;
         phase_q <= phase_d;
         rdv_q <= avs_read & ~rdv_q;
         rdata_q <= rdata_d;
         scan_q <= scan_d;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_glyph_byte;
      (st_q == ST_FETCH) ##1 (st_q == ST_WAIT && font_rd) ##1
         (st_q == ST_STORE);
   endsequence
   AST_GLYPH_START: assert property (code_go |=> s_glyph_byte)
      else $error("glyph fetch did not start");
   AST_GFX_STORE: assert property (gfx_wr |=>
      mem[$past(mem_wa)] == $past(wbyte)) else $error("byte not stored");
   AST_CLEAR_ZERO: assert property (st_q == ST_CLEAR |=>
      mem[$past(clr_q)] == 8'h00) else $error("clear wrote nonzero");
   AST_CLEAR_LEN: assert property ($rose(st_q == ST_CLEAR) |->
      ##[528:528] (st_q == ST_IDLE)) else $error("clear length wrong");
   AST_ADV_GFX: assert property (gfx_wr && col_q < win_cols_m1 |=>
      col_q == $past(col_q) + 4'h1) else $error("cursor not advanced");
   AST_ADV_FULL: assert property (st_q == ST_STORE && glyph_last
      && gfull_q && ({1'b0, col_q} + 5'h02 <= {1'b0, win_cols_m1})
      |=> col_q == $past(col_q) + 4'h2) else $error("full advance wrong");
   AST_FONT_TABLE: assert property (font_rd |->
      font_addr[FONT_AW-1 -: 2] == mode_q[MODE_FM +: 2])
      else $error("font table mismatch");
   AST_ICON_ROW: assert property (gfx_wr && icon |=>
      row_q == ICON_ROW_CODE) else $error("icon row left");
   AST_HSCROLL: assert property (step && hscr_q[SCR_EN]
      && !hscr_q[SCR_DIR] |=> hoff_q == $past(hoff_q) + $past(hunit))
      else $error("scroll step wrong");
   AST_HIDE_BUF: assert property (!in_win |=> scan_data == 8'h00)
      else $error("buffer area shown");
endmodule
`default_nettype wire

/* File: hw/lcdte_style.sv */
/*
 * Applies a rendering style (normal, bold, inverse) to one bitmap byte.
 * Assumes bit 7 is the leftmost dot.
 */
`timescale 1ns/1ns
`default_nettype none
module lcdte_style (
   input wire logic [7:0] raw,
   input wire lcdte_pkg::lcdte_style_e style,
   output logic [7:0] styled
);
   import lcdte_pkg::*;
   always_comb begin
      unique case (style)
         STY_BOLD: styled = raw | (raw >> 1);
         STY_INVERSE: styled = ~raw;
         default: styled = raw;
      endcase
   end
endmodule
`default_nettype wire

/* File: include/lcdte_pkg.sv */
/*
 * Constants, types and helpers shared by the text/graphic display engine.
 * Assumes a 100 MHz system clock and Avalon-MM byte addressing.
 */
`default_nettype none
package lcdte_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   // register word index; byte address is four times the index
   localparam logic [3:0] IDX_MODE = 4'h0;
   localparam logic [3:0] IDX_PWR = 4'h1;
   localparam logic [3:0] IDX_BLINK = 4'h2;
   localparam logic [3:0] IDX_COL = 4'h3;
   localparam logic [3:0] IDX_ROW = 4'h4;
   localparam logic [3:0] IDX_CUR = 4'h5;
   localparam logic [3:0] IDX_SYS = 4'h6;
   localparam logic [3:0] IDX_DATA = 4'h7;
   localparam logic [3:0] IDX_HSCR = 4'h8;
   localparam logic [3:0] IDX_VSCR = 4'h9;
   localparam logic [3:0] IDX_SPEED = 4'ha;
   // field positions
   localparam int MODE_FM = 0;
   localparam int MODE_FULL = 2;
   localparam int MODE_H8 = 3;
   localparam int MODE_STY = 4;
   localparam int PWR_CLR = 0;
   localparam int BLK_PER = 0;
   localparam int BLK_EN = 4;
   localparam int BLK_INV = 5;
   localparam int CUR_ON = 0;
   localparam int CUR_BLK = 1;
   localparam int CUR_H = 2;
   localparam int SYS_COLS = 0;
   localparam int SYS_ROWS = 4;
   localparam int SCR_EN = 0;
   localparam int SCR_DIR = 1;
   localparam int SCR_UNIT = 2;
   localparam int HS_TOP = 8;
   localparam int HS_BOT = 16;
   localparam int VS_LEFT = 8;
   localparam int VS_RIGHT = 12;
   // writable bits and values after reset
   localparam logic [31:0] MASK_MODE = 32'h0000_003f;
   localparam logic [31:0] MASK_BLINK = 32'h0000_003f;
   localparam logic [31:0] MASK_CUR = 32'h0000_003f;
   localparam logic [31:0] MASK_SYS = 32'h0000_01ff;
   localparam logic [31:0] MASK_HSCR = 32'h001f_1f1f;
   localparam logic [31:0] MASK_VSCR = 32'h0000_ff1f;
   localparam logic [31:0] MASK_SPEED = 32'h0000_00ff;
   localparam logic [31:0] RST_MODE = 32'h0000_0000;
   localparam logic [31:0] RST_BLINK = 32'h0000_0000;
   localparam logic [31:0] RST_CUR = 32'h0000_0000;
   localparam logic [31:0] RST_SYS = 32'h0000_01ff;
   localparam logic [31:0] RST_HSCR = 32'h001f_0000;
   localparam logic [31:0] RST_VSCR = 32'h0000_f000;
   localparam logic [31:0] RST_SPEED = 32'h0000_0000;
   // display memory geometry
   localparam int MEM_BYTES = 528;
   localparam logic [5:0] MEM_ROWS = 6'h21;
   localparam logic [6:0] ICON_ROW_CODE = 7'h50;
   localparam logic [5:0] ICON_MEM_ROW = 6'h20;
   localparam logic [9:0] CLR_LAST = 10'h20f;
   localparam logic [1:0] FM_GRAPHICS = 2'h0;
   localparam logic [4:0] GLYPH_H16 = 5'h10;
   localparam logic [4:0] GLYPH_H8 = 5'h08;
   localparam int FONT_AW = 23;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_FETCH = 3'h1,
      ST_WAIT = 3'h3,
      ST_STORE = 3'h2,
      ST_CLEAR = 3'h6
   } lcdte_state_e;
   typedef enum logic [1:0] {
      STY_NORMAL = 2'h0,
      STY_BOLD = 2'h1,
      STY_INVERSE = 2'h2
   } lcdte_style_e;
   function automatic logic [31:0] lcdte_merge(input logic [31:0] o,
      input logic [31:0] w, input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         if (be[i]) o[8*i +: 8] = w[8*i +: 8];
      end
      return o;
   endfunction
endpackage
`default_nettype wire

/* File: test/lcdte_font_model.sv */
/*
 * Font rom stand-in answering the engine's glyph fetches.
 * Assumes font_rd pulses for one clk_sys cycle with a stable address.
 */
`timescale 1ns/1ns
`default_nettype none
module lcdte_font_model (
   input wire logic clk_sys,
   input wire logic font_rd,
   input wire logic [lcdte_pkg::FONT_AW-1:0] font_addr,
   output logic [7:0] font_data
);
   import lcdte_pkg::*;
   function automatic logic [7:0] rom_byte(input logic [22:0] a);
      return a[7:0] ^ a[15:8] ^ {a[22:16], 1'b1};
   endfunction
   // byte valid the cycle after the fetch, changing junk otherwise
   always @(posedge clk_sys) begin
      if (font_rd === 1'b1) font_data <= rom_byte(font_addr);
      else font_data <= ~font_data;
   end
endmodule
`default_nettype wire

/* File: test/test_lcd_text_graphic_display_engine.sv */
/*
 * Self-checking bench: registers over avalon-mm, memory via scan port.
 * Assumes the font model answers fetches one cycle late.
 */
`timescale 1ns/1ns
`default_nettype none
module test_lcd_text_graphic_display_engine;
   import lcdte_pkg::*;
   logic clk_sys, rst, avs_read, avs_write, font_rd;
   logic frame_tick = 1'b0;
   logic avs_waitrequest;
   logic [5:0] avs_address, scan_row;
   logic [3:0] avs_byteenable, scan_col;
   logic [3:0] fcnt = 4'h0;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [FONT_AW-1:0] font_addr;
   logic [7:0] font_data, scan_data;
   int fails, tests_run, r, c;

   lcdte_engine lcdte_engine_inst (.clk_sys(clk_sys), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .font_rd(font_rd),
      .font_addr(font_addr), .font_data(font_data),
      .frame_tick(frame_tick), .scan_row(scan_row),
      .scan_col(scan_col), .scan_data(scan_data));
   lcdte_font_model lcdte_font_model_inst (.clk_sys(clk_sys),
      .font_rd(font_rd), .font_addr(font_addr), .font_data(font_data));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      fcnt <= fcnt + 4'h1;
      frame_tick <= (fcnt == 4'hf);
   end

   task end_sim;
      if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one avalon cycle, held until waitrequest is seen low
   task av(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 3000);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         fails++;
         end_sim();
      end
   endtask
   // returns at the edge where the engine samples a frame tick
   task wait_tick;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (frame_tick !== 1'b1 && n < 40);
      if (frame_tick !== 1'b1) begin
         fails++;
         end_sim();
      end
   endtask
   task wr(input logic [5:0] a, input logic [31:0] d);
      av(1'b1, a, d);
   endtask
   task rdc(input logic [5:0] a, input logic [31:0] e);
      av(1'b0, a, 32'h0);
      chk("readdata", q, e);
   endtask
   task scan(input logic [5:0] rw, input logic [3:0] cl, input logic [7:0] e);
      @(posedge clk_sys);
      scan_row <= rw;
      scan_col <= cl;
      @(posedge clk_sys);
      #1 chk("scan_data", {24'h0, scan_data}, {24'h0, e});
   endtask
   function automatic logic [5:0] ra(input logic [3:0] i);
      return {i, 2'b00};
   endfunction
   function automatic logic [7:0] rom(input logic [22:0] a);
      return a[7:0] ^ a[15:8] ^ {a[22:16], 1'b1};
   endfunction
   function automatic logic [7:0] bold(input logic [7:0] b);
      return b | (b >> 1);
   endfunction

   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      scan_row = 6'h00;
      scan_col = 4'h0;
      fails = 0;
      tests_run = 0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      rdc(ra(IDX_MODE), RST_MODE);
      rdc(ra(IDX_SYS), RST_SYS);
      rdc(ra(IDX_HSCR), RST_HSCR);
      rdc(ra(IDX_VSCR), RST_VSCR);
      wr(ra(IDX_CUR), 32'hffff_ffff);
      rdc(ra(IDX_CUR), MASK_CUR);
      wr(ra(IDX_BLINK), 32'hffff_ffff);
      rdc(ra(IDX_BLINK), MASK_BLINK);
      wr(ra(IDX_CUR), 32'h0);
      wr(ra(IDX_BLINK), 32'h0);
      wr(6'h2c, 32'hffff_ffff);
      rdc(6'h2c, 32'h0);
      // graphics bytes, advance and wrap at the window edge
      wr(ra(IDX_ROW), 32'h5);
      wr(ra(IDX_COL), 32'h3);
      wr(ra(IDX_DATA), 32'h5a);
      wr(ra(IDX_DATA), 32'ha5);
      wr(ra(IDX_COL), 32'hf);
      wr(ra(IDX_DATA), 32'h3c);
      wr(ra(IDX_DATA), 32'hc3);
      scan(6'h5, 4'h3, 8'h5a);
      scan(6'h5, 4'h4, 8'ha5);
      scan(6'h5, 4'hf, 8'h3c);
      scan(6'h6, 4'h0, 8'hc3);
      // icon row
      wr(ra(IDX_ROW), {25'h0, ICON_ROW_CODE});
      wr(ra(IDX_COL), 32'h2);
      wr(ra(IDX_DATA), 32'h81);
      wr(ra(IDX_DATA), 32'h18);
      scan(ICON_MEM_ROW, 4'h2, 8'h81);
      scan(ICON_MEM_ROW, 4'h3, 8'h18);
      // clear, next write stalls until done
      wr(ra(IDX_PWR), 32'h1);
      rdc(ra(IDX_PWR), 32'h1);
      wr(ra(IDX_MODE), 32'h29);
      rdc(ra(IDX_PWR), 32'h0);
      for (r = 0; r < 33; r++) begin
         for (c = 0; c < 16; c++) scan(r[5:0], c[3:0], 8'h00);
      end
      // half 8x8 inverse glyphs, table one
      wr(ra(IDX_ROW), 32'h0);
      wr(ra(IDX_COL), 32'h0);
      wr(ra(IDX_DATA), 32'h41);
      wr(ra(IDX_DATA), 32'h42);
      wr(ra(IDX_MODE), 32'h16);
      for (r = 0; r < 8; r++) begin
         for (c = 0; c < 2; c++) begin
            scan(r[5:0], c[3:0], ~rom({2'h1, 8'h00, 8'h41 + c[7:0],
               r[3:0], 1'b0}));
         end
      end
      // full bold two-byte glyph, table two
      wr(ra(IDX_ROW), 32'h10);
      wr(ra(IDX_COL), 32'h2);
      wr(ra(IDX_DATA), 32'ha4);
      rdc(ra(IDX_DATA), 32'h2);
      wr(ra(IDX_DATA), 32'h40);
      wr(ra(IDX_MODE), 32'h0);
      wr(ra(IDX_DATA), 32'h77);
      for (r = 0; r < 16; r++) begin
         for (c = 0; c < 2; c++) begin
            scan(6'h10 + r[5:0], 4'h2 + c[3:0], bold(rom({2'h2, 16'ha440,
               r[3:0], c[0]})));
         end
      end
      scan(6'h10, 4'h4, 8'h77);
      // exactly one left step of eight dots, then frozen by a slow speed
      wait_tick();
      wr(ra(IDX_HSCR), 32'h001f_000d);
      wait_tick();
      wr(ra(IDX_SPEED), 32'h0000_00ff);
      scan(6'h10, 4'h3, 8'h77);
      wr(ra(IDX_HSCR), RST_HSCR);
      wr(ra(IDX_SPEED), RST_SPEED);
      // invert inside the area rows only
      wr(ra(IDX_BLINK), 32'h20);
      scan(6'h10, 4'h4, 8'h88);
      wr(ra(IDX_HSCR), 32'h000f_0000);
      scan(6'h10, 4'h4, 8'h77);
      wr(ra(IDX_HSCR), RST_HSCR);
      wr(ra(IDX_BLINK), 32'h0);
      // cursor underline at the bottom of the cell, height one then two
      wr(ra(IDX_CUR), 32'h1);
      scan(6'h1f, 4'h5, 8'hff);
      scan(6'h1e, 4'h5, 8'h00);
      wr(ra(IDX_CUR), 32'h5);
      scan(6'h1e, 4'h5, 8'hff);
      wr(ra(IDX_CUR), 32'h0);
      // byte lane 1 only: window shrinks to 16 rows, lower half hidden
      avs_byteenable <= 4'h2;
      wr(ra(IDX_SYS), 32'h0);
      avs_byteenable <= 4'hf;
      rdc(ra(IDX_SYS), 32'h0000_00ff);
      scan(6'h10, 4'h4, 8'h00);
      wr(ra(IDX_SYS), RST_SYS);
      scan(6'h10, 4'h4, 8'h77);
      end_sim();
   end
endmodule
`default_nettype wire
